// ==== hw/fpmme_pkg.sv ====
package fpmme_pkg;
  localparam int AW = 8;
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_CORE_RD = 8'h08;
  localparam logic [7:0] OFF_CORE_RN = 8'h0c;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_SCR = 8'h18;
  localparam logic [7:0] OFF_EXC = 8'h1c;
  localparam logic [7:0] OFF_ID = 8'h20;
  localparam logic [7:0] OFF_SREG_IDX = 8'h24;
  localparam logic [7:0] OFF_SREG_DATA = 8'h28;
  localparam logic [3:0] SYS_ID = 4'h0;
  localparam logic [3:0] SYS_SCR = 4'h1;
  localparam logic [3:0] SYS_EXC = 4'h8;
  localparam logic [3:0] PC_REG = 4'hf;
  localparam int EX_BIT = 31;
  localparam int PRIV_BIT = 0;
  localparam int FLAG_LSB = 28;
  localparam int LEN_LSB = 16;
  localparam int EN_OFS = 8;
  localparam int EXC_POS [5] = '{0, 2, 3, 4, 7};
  localparam logic [31:0] SCR_RST = 32'h0000_0000;
  localparam logic [31:0] EXC_RST = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam int SB_BUSY = 0;
  localparam int SB_DONE = 1;
  localparam int SB_CONDF = 2;
  localparam int SB_UNDEF = 3;
  localparam int SB_EXCT = 4;
  localparam int SB_FCOPY = 5;
  localparam int SB_RVALID = 6;
  localparam logic FPU_MUL = 1'b0;
  localparam logic FPU_ADD = 1'b1;
  typedef enum {OP_NONE, OP_SYSRD, OP_TOSGL, OP_TOPAIR, OP_MSC} fpmme_op_t;
  typedef enum {
    ST_IDLE, ST_DEC, ST_SERIAL, ST_SYSRD, ST_MV1, ST_MV2,
    ST_RDOPS, ST_MUL, ST_MULW, ST_ADD, ST_ADDW, ST_WB, ST_NEXT
  } fpmme_state_t;
endpackage : fpmme_pkg

// ==== hw/fpmme_regfile.sv ====
`timescale 1ns/1ps
module fpmme_regfile #(
  parameter int W = 32,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];

  if (DEPTH != 2 ** AW) begin : g_chk
    $error("fpmme_regfile: DEPTH must equal 2**AW");
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read; a same-cycle write shows up one read later
  always_ff @(posedge clk_sys) begin
    rd_data <= mem[rd_addr];
  end
endmodule : fpmme_regfile

// ==== hw/fpmme_core.sv ====
// Functional notes
// RULE1 - act only when condition passes core flags
// RULE2 - system register read waits for serialization
// RULE3 - identity read: any mode, never traps
// RULE4 - status read: trap if pending, else value
// RULE5 - no exception processing while enable bit clear
// RULE6 - exception register read in user mode: undefined
// RULE7 - exception register read returns value, never traps
// RULE8 - pc destination with status source: flag copy
// RULE9 - double mul-sub: product plus negated destination
// RULE10 - double form only when double supported
// RULE11 - length one: exactly one operation
// RULE12 - longer length: iterate over element registers
// RULE13 - separately rounded multiply then add, unfused
// RULE14 - mul-sub raises five floating-point exceptions
// RULE15 - single mul-sub: negated destination plus product
// RULE16 - single index: four upper bits, one low
// RULE17 - core to single move copies unchanged
// RULE18 - internal format must recover exact value
// RULE19 - core must not use pc as source; the move decode accepts a pc core register field
// RULE20 - dual move fills consecutive single pair
// RULE21 - selector codes 0, 1, 8 choose registers
// RULE22 - dual move order; last single first unpredictable
// RULE23 - serialize until earlier operations complete
// RULE24 - decode by fixed opcode and precision bits
`timescale 1ns/1ps
module fpmme_core #(
  parameter bit DP_SUPPORT = 1'b1,
  parameter logic [31:0] ID_VALUE = 32'h0000_5a00  // arbitrary identity value
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fpmme_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fpu_req_valid,
  output logic fpu_req_op,
  output logic fpu_req_dbl,
  output logic [63:0] fpu_req_a,
  output logic [63:0] fpu_req_b,
  input wire logic fpu_rsp_valid,
  input wire logic [63:0] fpu_rsp_data,
  input wire logic [4:0] fpu_rsp_exc,
  output logic undef_req,
  output logic exc_trigger
);
  import fpmme_pkg::*;

  fpmme_state_t state;
  fpmme_op_t op, dec;
  logic [31:0] instr, flags, core_rd, core_rn, result, scr, exc;
  logic [4:0] sreg_idx, el_d, el_a, el_b, mem_rd_addr, mem_wr_addr;
  logic [6:1] stat;
  logic [2:0] vec_left, rd_cnt, cap_idx, last_word;
  logic [31:0] opw [6];
  logic [63:0] prod, a_w, b_w, c_w, neg_c;
  logic [31:0] mem_rd_data, mem_wr_data, rd_mux;
  logic [7:0] exc_hits;
  logic setup, wr_acc, go, unmapped, cond_ok, dbl, cap_vld, wb_hi, fpu_pend;
  logic mem_wr_en, trap, fcopy_ev;
  logic [3:0] sys_sel, rd_sel;

  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] nzcv);
    logic r;
    r = 1'b1;
    case (c[3:1])
      3'h0: r = nzcv[2];
      3'h1: r = nzcv[1];
      3'h2: r = nzcv[3];
      3'h3: r = nzcv[0];
      3'h4: r = nzcv[1] & ~nzcv[2];
      3'h5: r = nzcv[3] == nzcv[0];
      3'h6: r = ~nzcv[2] & (nzcv[3] == nzcv[0]);
      default: r = 1'b1;
    endcase
    return (c[3:1] != 3'h7) ? (r ^ c[0]) : 1'b1;
  endfunction : cond_pass

  // vector step stays inside the register bank
  function automatic logic [4:0] step(input logic [4:0] x, input logic d);
    return {x[4:3], 3'(x[2:0] + (d ? 3'h2 : 3'h1))};
  endfunction : step

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & ~pslverr;
  assign go = wr_acc && paddr == OFF_INSTR;
  assign cond_ok = cond_pass(instr[31:28], flags[31:28]);
  assign dbl = instr[8];
  assign sys_sel = instr[19:16];
  assign rd_sel = instr[15:12];
  assign a_w = {opw[1], opw[0]};
  assign b_w = {opw[3], opw[2]};
  assign c_w = {opw[5], opw[4]};
  assign last_word = dbl ? 3'h5 : 3'h2;
  // read data trail the counter by one cycle, so capture one word back
  assign cap_idx = dbl ? 3'(rd_cnt - 3'h1) : 3'({3'(rd_cnt - 3'h1), 1'b0});
  assign fcopy_ev = state == ST_SYSRD && sys_sel == SYS_SCR && !exc[EX_BIT]
                    && rd_sel == PC_REG; // RULE8 RULE5

  always_comb begin
    if (dbl) begin
      neg_c = {~c_w[63], c_w[62:0]}; // RULE9
    end else begin
      neg_c = {c_w[63:32], ~c_w[31], c_w[30:0]}; // RULE15
    end
  end

  // fixed opcode bits plus the precision bit pick the operation
  always_comb begin
    dec = OP_NONE;
    if (instr[11:9] == 3'b101) begin // RULE24
      if (instr[27:20] == 8'hef && instr[4] && !instr[8]) begin
        dec = OP_SYSRD;
      end else if (instr[27:20] == 8'he0 && instr[4] && !instr[8]) begin
        dec = OP_TOSGL;
      end else if (instr[27:20] == 8'hc4 && instr[7:6] == 2'b00 && instr[4] && !instr[8]) begin
        dec = OP_TOPAIR;
      end else if (instr[27:23] == 5'b11100 && instr[21:20] == 2'b01 && !instr[6]
                   && !instr[4] && !(instr[8] && instr[22])) begin
        dec = OP_MSC;
      end
    end
  end

  always_comb begin
    exc_hits = 8'h00;
    trap = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (fpu_rsp_valid && fpu_rsp_exc[i]) begin // RULE14
        exc_hits[EXC_POS[i]] = 1'b1;
        if (scr[EXC_POS[i] + EN_OFS]) begin
          trap = 1'b1;
        end
      end
    end
  end

  always_comb begin
    unmapped = 1'b0;
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_INSTR: rd_mux = instr;
      OFF_FLAGS: rd_mux = flags;
      OFF_CORE_RD: rd_mux = core_rd;
      OFF_CORE_RN: rd_mux = core_rn;
      OFF_RESULT: rd_mux = result;
      OFF_STATUS: rd_mux = {20'h00000, rd_sel, 1'b0, stat, state != ST_IDLE};
      OFF_SCR: rd_mux = scr;
      OFF_EXC: rd_mux = exc;
      OFF_ID: rd_mux = ID_VALUE;
      OFF_SREG_IDX: rd_mux = {27'h0000000, sreg_idx};
      OFF_SREG_DATA: rd_mux = mem_rd_data;
      default: unmapped = 1'b1;
    endcase
  end

  // zero-wait slave: answer is ready in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & (unmapped | (pwrite & paddr == OFF_INSTR & state != ST_IDLE));
      if (setup & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      instr <= 32'h0000_0000;
      core_rd <= 32'h0000_0000;
      core_rn <= 32'h0000_0000;
      sreg_idx <= 5'h00;
    end else if (wr_acc) begin
      case (paddr)
        OFF_INSTR: instr <= pwdata;
        OFF_CORE_RD: core_rd <= pwdata;
        OFF_CORE_RN: core_rn <= pwdata;
        OFF_SREG_IDX: sreg_idx <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  // hardware flag copy wins over a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flags <= FLAGS_RST;
    end else begin
      if (wr_acc && paddr == OFF_FLAGS) begin
        flags <= pwdata;
      end
      if (fcopy_ev) begin
        flags[31:28] <= scr[31:28]; // RULE8
      end
    end
  end

  // sticky exception bits: a hit survives a clearing write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scr <= SCR_RST;
    end else if (wr_acc && paddr == OFF_SCR) begin
      scr <= pwdata | {24'h000000, exc_hits}; // RULE14
    end else begin
      scr <= scr | {24'h000000, exc_hits};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      exc <= EXC_RST;
    end else begin
      if (wr_acc && paddr == OFF_EXC) begin
        exc <= pwdata;
      end
      if (trap) begin
        exc[EX_BIT] <= 1'b1;
      end
    end
  end

  always_comb begin
    mem_rd_addr = sreg_idx;
    if (state == ST_RDOPS) begin
      case (dbl ? {1'b0, rd_cnt[2:1]} : rd_cnt)
        3'h0: mem_rd_addr = el_a;
        3'h1: mem_rd_addr = el_b;
        default: mem_rd_addr = el_d;
      endcase
      mem_rd_addr[0] = mem_rd_addr[0] | (dbl & rd_cnt[0]);
    end
  end

  always_comb begin
    mem_wr_en = 1'b0;
    mem_wr_addr = el_b;
    mem_wr_data = core_rd;
    case (state)
      ST_MV1: mem_wr_en = 1'b1; // RULE20
      ST_MV2: begin
        mem_wr_en = 1'b1;
        mem_wr_addr = (op == OP_TOPAIR) ? 5'(el_b + 5'h01) : el_a;
        mem_wr_data = (op == OP_TOPAIR) ? core_rn : core_rd; // RULE17 RULE18
      end
      ST_WB: begin
        mem_wr_en = 1'b1;
        mem_wr_addr = el_d | {4'h0, wb_hi};
        mem_wr_data = wb_hi ? prod[63:32] : prod[31:0];
      end
      default: ;
    endcase
  end

  // raw bits are stored; no internal format to undo later
  fpmme_regfile #(.W(32), .DEPTH(32), .AW(5)) u_regs (
    .clk_sys(clk_sys),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  always_ff @(posedge clk_sys) begin
    cap_vld <= state == ST_RDOPS;
    if (cap_vld) begin
      opw[cap_idx] <= mem_rd_data;
    end
    if (state == ST_RDOPS) begin
      rd_cnt <= 3'(rd_cnt + 3'h1);
    end else begin
      rd_cnt <= 3'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op <= OP_NONE;
      stat <= 6'h00;
      result <= 32'h0000_0000;
      el_d <= 5'h00;
      el_a <= 5'h00;
      el_b <= 5'h00;
      vec_left <= 3'h0;
      prod <= 64'h0;
      wb_hi <= 1'b0;
      fpu_pend <= 1'b0;
      fpu_req_valid <= 1'b0;
      fpu_req_op <= FPU_MUL;
      fpu_req_dbl <= 1'b0;
      fpu_req_a <= 64'h0;
      fpu_req_b <= 64'h0;
      undef_req <= 1'b0;
      exc_trigger <= 1'b0;
    end else begin
      fpu_req_valid <= 1'b0;
      undef_req <= 1'b0;
      exc_trigger <= 1'b0;
      if (fpu_req_valid) begin
        fpu_pend <= 1'b1;
      end else if (fpu_rsp_valid) begin
        fpu_pend <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (go) begin
            stat <= 6'h00;
            state <= ST_DEC;
          end
        end
        ST_DEC: begin
          op <= dec;
          el_d <= {instr[15:12], dbl ? 1'b0 : instr[22]}; // RULE16
          el_a <= {instr[19:16], dbl ? 1'b0 : instr[7]};
          el_b <= {instr[3:0], dbl ? 1'b0 : instr[5]};
          vec_left <= (instr[15:13] == 3'h0) ? 3'h0 : scr[LEN_LSB +: 3]; // RULE11 RULE12
          if (!cond_ok) begin // RULE1
            stat[SB_CONDF] <= 1'b1;
            stat[SB_DONE] <= 1'b1;
            state <= ST_IDLE;
          end else if (dec == OP_SYSRD) begin
            state <= ST_SERIAL;
          end else if (dec == OP_TOSGL) begin
            state <= ST_MV2;
          end else if (dec == OP_TOPAIR) begin
            state <= ST_MV1;
          end else if (dec == OP_MSC && (!dbl || DP_SUPPORT)) begin // RULE10
            state <= ST_RDOPS;
          end else begin
            undef_req <= 1'b1;
            stat[SB_UNDEF] <= 1'b1;
            stat[SB_DONE] <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_SERIAL: begin
          if (!fpu_pend) begin // RULE2 RULE23
            state <= ST_SYSRD;
          end
        end
        ST_SYSRD: begin
          stat[SB_DONE] <= 1'b1;
          state <= ST_IDLE;
          case (sys_sel) // RULE21
            SYS_ID: begin
              if (rd_sel == PC_REG) begin
                undef_req <= 1'b1;
                stat[SB_UNDEF] <= 1'b1;
              end else begin
                result <= ID_VALUE; // RULE3
                stat[SB_RVALID] <= 1'b1;
              end
            end
            SYS_SCR: begin
              if (exc[EX_BIT]) begin // RULE4 RULE5
                exc_trigger <= 1'b1;
                stat[SB_EXCT] <= 1'b1;
              end else if (rd_sel == PC_REG) begin
                stat[SB_FCOPY] <= 1'b1;
              end else begin
                result <= scr;
                stat[SB_RVALID] <= 1'b1;
              end
            end
            SYS_EXC: begin
              if (!flags[PRIV_BIT] || rd_sel == PC_REG) begin // RULE6
                undef_req <= 1'b1;
                stat[SB_UNDEF] <= 1'b1;
              end else begin
                result <= exc; // RULE7
                stat[SB_RVALID] <= 1'b1;
              end
            end
            default: begin
              undef_req <= 1'b1;
              stat[SB_UNDEF] <= 1'b1;
            end
          endcase
        end
        ST_MV1: state <= ST_MV2;
        ST_MV2: begin
          stat[SB_DONE] <= 1'b1;
          state <= ST_IDLE;
        end
        ST_RDOPS: begin
          if (rd_cnt == last_word) begin
            state <= ST_MUL;
          end
        end
        // two separately rounded steps, never fused
        ST_MUL: begin
          fpu_req_valid <= 1'b1; // RULE13
          fpu_req_op <= FPU_MUL;
          fpu_req_dbl <= dbl;
          fpu_req_a <= a_w;
          fpu_req_b <= b_w;
          state <= ST_MULW;
        end
        ST_MULW: begin
          if (fpu_rsp_valid) begin
            prod <= fpu_rsp_data;
            state <= ST_ADD;
          end
        end
        ST_ADD: begin
          fpu_req_valid <= 1'b1; // RULE9 RULE15
          fpu_req_op <= FPU_ADD;
          fpu_req_a <= neg_c;
          fpu_req_b <= prod;
          state <= ST_ADDW;
        end
        ST_ADDW: begin
          if (fpu_rsp_valid) begin
            prod <= fpu_rsp_data;
            wb_hi <= 1'b0;
            state <= ST_WB;
          end
        end
        ST_WB: begin
          wb_hi <= 1'b1;
          if (!dbl || wb_hi) begin
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (vec_left == 3'h0) begin
            stat[SB_DONE] <= 1'b1;
            state <= ST_IDLE;
          end else begin
            vec_left <= 3'(vec_left - 3'h1); // RULE12
            el_d <= step(el_d, dbl);
            el_a <= step(el_a, dbl);
            el_b <= (el_b[4:3] == 2'h0) ? el_b : step(el_b, dbl);
            state <= ST_RDOPS;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence sysrd_s(logic [3:0] s);
    state == ST_SYSRD && sys_sel == s;
  endsequence
  sequence add_req_s;
    fpu_req_valid && fpu_req_op == FPU_ADD;
  endsequence

  cond_skip_a: assert property ( // RULE1
    state == ST_DEC && !cond_ok |=> state == ST_IDLE && !mem_wr_en && !fpu_req_valid)
    else $error("failed condition still acted");
  serial_wait_a: assert property ( // RULE2
    state == ST_SYSRD |-> $past(state) == ST_SERIAL && !$past(fpu_pend))
    else $error("system read before serialization");
  id_read_a: assert property ( // RULE3
    sysrd_s(SYS_ID) and rd_sel != PC_REG |=> result == ID_VALUE && !exc_trigger)
    else $error("identity read wrong");
  scr_read_a: assert property ( // RULE4
    sysrd_s(SYS_SCR) and !exc[EX_BIT] && rd_sel != PC_REG |=> result == $past(scr))
    else $error("status read value wrong");
  exc_gate_a: assert property ( // RULE5
    exc_trigger |-> $past(exc[EX_BIT]) && $past(sys_sel) == SYS_SCR)
    else $error("exception processing with enable clear");
  user_undef_a: assert property ( // RULE6
    sysrd_s(SYS_EXC) and !flags[PRIV_BIT] |=> undef_req && !stat[SB_RVALID])
    else $error("user read of exception register allowed");
  exc_read_a: assert property ( // RULE7
    sysrd_s(SYS_EXC) and flags[PRIV_BIT] && rd_sel != PC_REG
    |=> result == $past(exc) && !exc_trigger)
    else $error("exception register read wrong");
  flag_copy_a: assert property ( // RULE8
    fcopy_ev |=> flags[31:28] == $past(scr[31:28]) ##1 state == ST_IDLE)
    else $error("flag copy missing");
  neg_dest_a: assert property ( // RULE9
    add_req_s |-> fpu_req_b == prod && (fpu_req_dbl ? fpu_req_a[63] != opw[5][31]
    : fpu_req_a[31] != opw[4][31]))
    else $error("add step operands wrong");
  dp_gate_a: assert property ( // RULE10
    fpu_req_valid && fpu_req_dbl |-> DP_SUPPORT)
    else $error("double op without support");
  unfused_a: assert property ( // RULE13
    add_req_s |-> $past(state, 2) == ST_MULW || $past(state) == ST_ADD)
    else $error("add issued without prior multiply");
  pair_a: assert property ( // RULE20
    state == ST_MV1 |-> mem_wr_en ##1 mem_wr_en && mem_wr_addr == 5'($past(mem_wr_addr) + 5'h01))
    else $error("pair move not consecutive");
endmodule : fpmme_core

// ==== verif/fpmme_fpu_model.sv ====
`timescale 1ns/1ps
module fpmme_fpu_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fpu_req_valid,
  input wire logic fpu_req_op,
  input wire logic fpu_req_dbl,
  input wire logic [63:0] fpu_req_a,
  input wire logic [63:0] fpu_req_b,
  input wire logic slow,
  input wire logic [4:0] exc_in,
  output logic fpu_rsp_valid,
  output logic [63:0] fpu_rsp_data,
  output logic [4:0] fpu_rsp_exc
);
  logic [63:0] res;
  logic [31:0] s_res;
  logic [2:0] cnt;
  logic pend;
  // integer stand-in for the arithmetic: each op answers on its own
  always_comb begin
    s_res = fpu_req_op ? fpu_req_a[31:0] + fpu_req_b[31:0] : fpu_req_a[31:0] * fpu_req_b[31:0];
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend <= 1'b0;
      cnt <= 3'h0;
      res <= 64'h0;
      fpu_rsp_valid <= 1'b0;
      fpu_rsp_data <= 64'h0;
      fpu_rsp_exc <= 5'h0;
    end else begin
      fpu_rsp_valid <= 1'b0;
      fpu_rsp_exc <= 5'h0;
      // bus toggles when not answering, so stale data never looks valid
      fpu_rsp_data <= ~fpu_rsp_data;
      if (fpu_req_valid) begin
        pend <= 1'b1;
        cnt <= slow ? 3'h5 : 3'h0;
        if (fpu_req_dbl) begin
          res <= fpu_req_op ? fpu_req_a + fpu_req_b : fpu_req_a * fpu_req_b;
        end else begin
          res <= {32'h0, s_res};
        end
      end else if (pend) begin
        if (cnt == 3'h0) begin
          pend <= 1'b0;
          fpu_rsp_valid <= 1'b1;
          fpu_rsp_data <= res;
          fpu_rsp_exc <= exc_in;
        end else begin
          cnt <= cnt - 3'h1;
        end
      end
    end
  end
endmodule : fpmme_fpu_model

// ==== verif/tb_fpmme_core.sv ====
`timescale 1ns/1ps
module tb_fpmme_core;
  import fpmme_pkg::*;
  localparam logic [31:0] ID_V = 32'h0000_3c00; // arbitrary value
  localparam logic [3:0] AL = 4'he;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0;
  logic [4:0] exc_in = 5'h0;
  logic [31:0] prdata, st, v, s4, s5;
  logic pready, pslverr, err;
  logic fpu_req_valid, fpu_req_op, fpu_req_dbl, fpu_rsp_valid, undef_req, exc_trigger;
  logic [63:0] fpu_req_a, fpu_req_b, fpu_rsp_data, dd;
  logic [4:0] fpu_rsp_exc;
  int fails = 0;
  int samples_checked = 0;
  int n_undef = 0;
  int n_exct = 0;
  int n_req = 0;
  fpmme_core #(.DP_SUPPORT(1'b1), .ID_VALUE(ID_V)) u_fpmme_core (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fpu_req_valid(fpu_req_valid), .fpu_req_op(fpu_req_op), .fpu_req_dbl(fpu_req_dbl),
    .fpu_req_a(fpu_req_a), .fpu_req_b(fpu_req_b), .fpu_rsp_valid(fpu_rsp_valid),
    .fpu_rsp_data(fpu_rsp_data), .fpu_rsp_exc(fpu_rsp_exc), .undef_req(undef_req),
    .exc_trigger(exc_trigger));
  fpmme_fpu_model u_fpmme_fpu_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .fpu_req_valid(fpu_req_valid),
    .fpu_req_op(fpu_req_op), .fpu_req_dbl(fpu_req_dbl), .fpu_req_a(fpu_req_a),
    .fpu_req_b(fpu_req_b), .slow(slow), .exc_in(exc_in), .fpu_rsp_valid(fpu_rsp_valid),
    .fpu_rsp_data(fpu_rsp_data), .fpu_rsp_exc(fpu_rsp_exc));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (undef_req === 1'b1) n_undef++;
    if (exc_trigger === 1'b1) n_exct++;
    if (fpu_req_valid === 1'b1) n_req++;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  endtask : chk1
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait for ready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [AW-1:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic run(input logic [31:0] ins);
    int n;
    wr(OFF_INSTR, ins);
    n = 0;
    do begin
      rd(OFF_STATUS, st);
      n++;
    end while ((st[SB_BUSY] !== 1'b0 || st[SB_DONE] !== 1'b1) && n < 300);
    if (n >= 300) begin
      fails++;
      $display("unexpected at %0t: instruction hung", $time);
    end
  endtask : run
  task automatic sget(input logic [4:0] idx, output logic [31:0] q);
    wr(OFF_SREG_IDX, {27'h0, idx});
    repeat (2) @(posedge clk_sys);
    rd(OFF_SREG_DATA, q);
  endtask : sget
  function automatic logic [31:0] sr(input logic [3:0] c, input logic [3:0] r,
                                     input logic [3:0] d);
    sr = {c, 8'hef, r, d, 12'ha10};
  endfunction : sr
  function automatic logic [31:0] ms(input logic dbl, input logic [4:0] d,
                                     input logic [4:0] n, input logic [4:0] m);
    ms = {AL, 5'b11100, d[0], 2'b01, n[4:1], d[4:1], 3'b101, dbl, n[0], 1'b0, m[0], 1'b0,
          m[4:1]};
  endfunction : ms
  // single move and dual move encodings
  function automatic logic [31:0] mv(input logic [4:0] s);
    mv = {AL, 8'he0, s[4:1], 4'h1, 4'ha, s[0], 3'b001, 4'h0};
  endfunction : mv
  function automatic logic [31:0] dm(input logic [4:0] s);
    dm = {AL, 8'hc4, 4'h2, 4'h1, 4'ha, 2'b00, s[0], 1'b1, s[4:1]};
  endfunction : dm
  task automatic pair(input logic [4:0] s, input logic [31:0] a, input logic [31:0] b);
    wr(OFF_CORE_RD, a);
    wr(OFF_CORE_RN, b);
    run(dm(s));
  endtask : pair
  initial begin
    #900000;
    fails++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFF_SCR, v);
    chk(v, SCR_RST);
    rd(OFF_EXC, v);
    chk(v, EXC_RST);
    rd(8'h40, v);
    chk1(err, 1'b1);
    run(sr(AL, SYS_ID, 4'h2));
    rd(OFF_RESULT, v);
    chk(v, ID_V);
    chk(st[11:8], 32'h2);
    wr(OFF_SCR, 32'h5000_0000);
    run(sr(AL, SYS_SCR, 4'h3));
    rd(OFF_RESULT, v);
    chk(v, 32'h5000_0000);
    chk1(st[SB_EXCT], 1'b0);
    wr(OFF_EXC, 32'h4000_0000);
    run(sr(AL, SYS_EXC, 4'h4));
    chk1(st[SB_UNDEF], 1'b1);
    chk(n_undef, 32'h1);
    wr(OFF_FLAGS, 32'h0000_0001);
    run(sr(AL, SYS_EXC, 4'h4));
    rd(OFF_RESULT, v);
    chk(v, 32'h4000_0000);
    // equal condition fails while the zero flag is clear
    run(sr(4'h0, SYS_ID, 4'h4));
    chk1(st[SB_CONDF], 1'b1);
    rd(OFF_RESULT, v);
    chk(v, 32'h4000_0000);
    run(sr(AL, SYS_SCR, PC_REG));
    chk1(st[SB_FCOPY], 1'b1);
    rd(OFF_FLAGS, v);
    chk(v, 32'h5000_0001);
    run(sr(4'h0, SYS_ID, 4'h5));
    rd(OFF_RESULT, v);
    chk(v, ID_V);
    wr(OFF_CORE_RD, 32'h0000_0007);
    run(mv(5'd1));
    sget(5'd1, v);
    chk(v, 32'h0000_0007);
    pair(5'd2, 32'h0000_0003, 32'h0000_0005);
    sget(5'd2, v);
    chk(v, 32'h0000_0003);
    sget(5'd3, v);
    chk(v, 32'h0000_0005);
    n_req = 0;
    run(ms(1'b0, 5'd1, 5'd2, 5'd3));
    chk(n_req, 32'h2);
    sget(5'd1, v);
    chk(v, (32'h0000_0007 ^ 32'h8000_0000) + 32'h0000_000f);
    pair(5'd4, 32'h0000_0011, 32'h0000_0001);
    pair(5'd6, 32'h0000_0002, 32'h0000_0000);
    slow <= 1'b1;
    dd = (64'h0000_0001_0000_0011 ^ 64'h8000_0000_0000_0000) + 64'h2 * 64'h0000_0005_0000_0003;
    run(ms(1'b1, 5'd4, 5'd6, 5'd2));
    sget(5'd4, s4);
    sget(5'd5, s5);
    chk({s5, s4} == dd, 32'h1);
    // two elements with invalid-operation trap enabled; sources written first
    pair(5'd8, 32'h0000_0001, 32'h0000_0002);
    pair(5'd16, 32'h0000_0004, 32'h0000_0005);
    wr(OFF_SCR, 32'h5001_0100);
    exc_in <= 5'h01;
    n_req = 0;
    run(ms(1'b0, 5'd8, 5'd16, 5'd2));
    chk(n_req, 32'h4);
    exc_in <= 5'h00;
    // second element: next destination and source, bank-0 operand held
    sget(5'd9, v);
    chk(v, (32'h0000_0002 ^ 32'h8000_0000) + 32'h0000_000f);
    rd(OFF_SCR, v);
    chk1(v[0], 1'b1);
    rd(OFF_EXC, v);
    chk1(v[EX_BIT], 1'b1);
    run(sr(AL, SYS_ID, 4'h6));
    chk1(st[SB_EXCT], 1'b0);
    run(sr(AL, SYS_EXC, 4'h6));
    chk1(st[SB_EXCT], 1'b0);
    run(sr(AL, SYS_SCR, 4'h6));
    chk1(st[SB_EXCT], 1'b1);
    chk(n_exct, 32'h1);
    final_report();
  end
endmodule : tb_fpmme_core
